//--- core/ccs_pkg.sv
package ccs_pkg;

    // ****************************************
    // sizes and layout
    // ****************************************
    localparam int NUM_CH        = 4;
    localparam int IMG_BYTES     = 16;
    localparam int STRIDE_COMPACT = 2;
    localparam int STRIDE_PACKED = 3;
    localparam int STRIDE_ALIGNED = 4;
    localparam int DATA_AT_COMPACT = 0;
    localparam int DATA_AT_PACKED = 1;
    localparam int DATA_AT_ALIGNED = 2;
    localparam int RSVD_AT_ALIGNED = 1;

    // ****************************************
    // control and status byte fields, feature register enable bits
    // ****************************************
    localparam int CTL_MODE_BIT  = 7;
    localparam int CTL_RW_BIT    = 6;
    localparam int ST_ERR_BIT    = 6;
    localparam int ST_OVER_BIT   = 1;
    localparam int ST_UNDER_BIT  = 0;
    localparam int FEAT_EN_LIM1  = 9;
    localparam int FEAT_EN_LIM2  = 10;

    localparam logic [1:0] LIM_OFF   = 2'h0;
    localparam logic [1:0] LIM_BELOW = 2'h1;
    localparam logic [1:0] LIM_ABOVE = 2'h2;
    localparam logic [1:0] LIM_EQUAL = 2'h3;

    // ****************************************
    // parameter register numbers and reset values
    // ****************************************
    localparam logic [5:0]  REG_RAW   = 6'h00;
    localparam logic [5:0]  REG_DIAG  = 6'h06;
    localparam logic [5:0]  REG_OVR   = 6'h15;
    localparam logic [5:0]  REG_UND   = 6'h16;
    localparam logic [5:0]  REG_FEAT  = 6'h20;
    localparam logic [5:0]  REG_LIM1  = 6'h21;
    localparam logic [5:0]  REG_LIM2  = 6'h22;
    localparam logic [15:0] OVR_RST   = 16'h0fff;
    localparam logic [15:0] UND_RST   = 16'h0000;
    localparam logic [15:0] FEAT_RST  = 16'h0906;
    localparam logic [15:0] LIM_RST   = 16'h0000;

    typedef struct packed {
        logic complete;
        logic motorola;
        logic align;
    } ccs_cfg_s;

    typedef struct packed {
        logic [7:0]  stat;
        logic [15:0] data;
        logic [7:0]  pd_stat;
        logic [15:0] pd_data;
        logic [15:0] raw;
        logic [15:0] ovr;
        logic [15:0] und;
        logic [15:0] feat;
        logic [15:0] lim1;
        logic [15:0] lim2;
    } ccs_chan_s;

    typedef struct packed {
        ccs_chan_s [NUM_CH-1:0]    ch;
        logic [IMG_BYTES*8-1:0]    in_img;
        logic [IMG_BYTES-1:0]      in_used;
        logic [IMG_BYTES-1:0]      out_used;
    } ccs_state_s;

endpackage : ccs_pkg

//--- core/ccs_chan_regs.sv
`timescale 1ns/1ps
// How it works
// - complete evaluation puts status/control byte beside each channel's two data bytes.
// - word alignment pads so each channel starts on a word boundary.
// - data word byte order selectable, little or big endian.
// - data split into low and high byte, placed per selected order.
// - padding bytes ignored on write and read back as zero.
// - unused byte positions are neither driven nor sampled.
// - each channel has its own status byte in and control byte out.
// - channels two to four behave exactly like channel one.
// - control bit 7 clear selects process data mode; other bits ignored.
// - process data mode clears status bit 7; bit 6 is general error.
// - status bits 5:4 give second limit: off, below, above, equal.
// - status bits 3:2 give first limit with the same encoding.
// - status bit 1 set when value exceeds measuring range.
// - status bit 0 set when value falls below lower range limit.
// - bits 5:0 pick register; read data in input word, write from output.
// - register access acknowledged by status bit 7 with direction in bit 6.
// - status bits 5:0 echo the register number requested, valid or not.
// - each channel owns a parameter set reached only by its handshake.
// - without complete evaluation only data words in input image are used.
// - complete aligned layout: status/control plus reserved, then data word.
module ccs_chan_regs
    import ccs_pkg::*;
(
    input  wire logic                              ref_clk_i,
    input  wire logic                              rst_n_i,
    input  wire logic                              cfg_complete_i,
    input  wire logic                              cfg_motorola_i,
    input  wire logic                              cfg_align_i,
    input  wire logic [NUM_CH-1:0][15:0]           adc_data_i,
    input  wire logic [NUM_CH-1:0]                 adc_valid_i,
    input  wire logic [IMG_BYTES*8-1:0]            out_image_i,
    output logic      [IMG_BYTES*8-1:0]            in_image_o,
    output logic      [IMG_BYTES-1:0]              in_used_o,
    output logic      [IMG_BYTES-1:0]              out_used_o
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic int chan_base(input int k, input ccs_cfg_s c);
        if (!c.complete)
            return k * STRIDE_COMPACT;
        else if (c.align)
            return k * STRIDE_ALIGNED;
        else
            return k * STRIDE_PACKED;
    endfunction : chan_base

    // byte position of the low (hi=0) or high (hi=1) data byte of a channel
    function automatic int data_pos(input int k, input ccs_cfg_s c, input logic hi);
        int at;
        at = !c.complete ? DATA_AT_COMPACT : (c.align ? DATA_AT_ALIGNED : DATA_AT_PACKED);
        return chan_base(k, c) + at + int'(hi ^ c.motorola);
    endfunction : data_pos

    function automatic logic [1:0] lim_cmp(input logic [15:0] v, input logic [15:0] lim,
                                           input logic en);
        if (!en)
            return LIM_OFF;
        else if ($signed(v) < $signed(lim))
            return LIM_BELOW;
        else if ($signed(v) > $signed(lim))
            return LIM_ABOVE;
        else
            return LIM_EQUAL;
    endfunction : lim_cmp

    function automatic logic [15:0] reg_read(input ccs_chan_s c, input logic [5:0] n);
        case (n)
            REG_RAW:  return c.raw;
            REG_DIAG: return {8'h00, c.pd_stat};
            REG_OVR:  return c.ovr;
            REG_UND:  return c.und;
            REG_FEAT: return c.feat;
            REG_LIM1: return c.lim1;
            REG_LIM2: return c.lim2;
            default:  return 16'h0000;
        endcase
    endfunction : reg_read

    // ****************************************
    // state
    // ****************************************
    ccs_state_s          s;
    ccs_state_s          next_s;
    ccs_cfg_s            cfg;
    logic [NUM_CH-1:0][7:0]  ctrl_byte;
    logic [NUM_CH-1:0][15:0] wr_word;

    assign cfg = '{complete: cfg_complete_i, motorola: cfg_motorola_i, align: cfg_align_i};

    // ****************************************
    // output image decode
    // ****************************************
    always_comb begin
        for (int k = 0; k < NUM_CH; k++) begin
            // no control byte reachable in compact mode, so it reads as process data mode
            ctrl_byte[k] = cfg.complete ? out_image_i[8*chan_base(k, cfg) +: 8] : 8'h00;
            wr_word[k]   = {out_image_i[8*data_pos(k, cfg, 1'b1) +: 8],
                            out_image_i[8*data_pos(k, cfg, 1'b0) +: 8]};
        end
    end

    // ****************************************
    // channel logic and image build
    // ****************************************
    always_comb begin
        ccs_chan_s   c;
        logic [15:0] v;
        logic [7:0]  st;
        int          b;
        c      = '0;
        v      = '0;
        st     = '0;
        b      = 0;
        next_s = s;
        next_s.in_img   = '0;
        next_s.in_used  = '0;
        next_s.out_used = '0;
        // same code for every channel; each owns its own register set
        for (int k = 0; k < NUM_CH; k++) begin
            c = s.ch[k];
            if (ctrl_byte[k][CTL_MODE_BIT]) begin
                if (ctrl_byte[k][CTL_RW_BIT]) begin
                    // repeated while request stands; rewriting the same value is harmless
                    case (ctrl_byte[k][5:0])
                        REG_OVR:  c.ovr  = wr_word[k];
                        REG_UND:  c.und  = wr_word[k];
                        REG_FEAT: c.feat = wr_word[k];
                        REG_LIM1: c.lim1 = wr_word[k];
                        REG_LIM2: c.lim2 = wr_word[k];
                        default:  c.raw  = c.raw;
                    endcase
                end
                c.stat = {1'b1, ctrl_byte[k][CTL_RW_BIT], ctrl_byte[k][5:0]};
                c.data = reg_read(c, ctrl_byte[k][5:0]);
            end else begin
                // remaining control bits are don't-care here
                if (adc_valid_i[k]) begin
                    c.raw = adc_data_i[k];
                    v     = adc_data_i[k];
                    st    = 8'h00;
                    if ($signed(v) > $signed(c.ovr)) begin
                        st[ST_OVER_BIT] = 1'b1;
                        v = c.ovr;
                    end else if ($signed(v) < $signed(c.und)) begin
                        st[ST_UNDER_BIT] = 1'b1;
                        v = c.und;
                    end
                    st[5:4]         = lim_cmp(v, c.lim2, c.feat[FEAT_EN_LIM2]);
                    st[3:2]         = lim_cmp(v, c.lim1, c.feat[FEAT_EN_LIM1]);
                    st[ST_ERR_BIT]  = st[ST_OVER_BIT] | st[ST_UNDER_BIT];
                    c.pd_stat = st;
                    c.pd_data = v;
                end
                // flags and value always leave together
                c.stat = c.pd_stat;
                c.data = c.pd_data;
            end
            next_s.ch[k] = c;

            b = chan_base(k, cfg);
            if (cfg.complete) begin
                next_s.in_img[8*b +: 8] = c.stat;
                next_s.in_used[b]       = 1'b1;
                next_s.out_used[b]      = 1'b1;
                if (cfg.align) begin
                    // reserved byte: occupied, reads zero, its write value ignored
                    next_s.in_used[b+RSVD_AT_ALIGNED]  = 1'b1;
                    next_s.out_used[b+RSVD_AT_ALIGNED] = 1'b1;
                end
                next_s.out_used[data_pos(k, cfg, 1'b0)] = 1'b1;
                next_s.out_used[data_pos(k, cfg, 1'b1)] = 1'b1;
            end
            next_s.in_img[8*data_pos(k, cfg, 1'b0) +: 8] = c.data[7:0];
            next_s.in_img[8*data_pos(k, cfg, 1'b1) +: 8] = c.data[15:8];
            next_s.in_used[data_pos(k, cfg, 1'b0)]       = 1'b1;
            next_s.in_used[data_pos(k, cfg, 1'b1)]       = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            s <= '0;
            for (int k = 0; k < NUM_CH; k++) begin
                s.ch[k].ovr  <= OVR_RST;
                s.ch[k].und  <= UND_RST;
                s.ch[k].feat <= FEAT_RST;
                s.ch[k].lim1 <= LIM_RST;
                s.ch[k].lim2 <= LIM_RST;
            end
        end else begin
            s <= next_s;
        end
    end

    assign in_image_o = s.in_img;
    assign in_used_o  = s.in_used;
    assign out_used_o = s.out_used;

    // ****************************************
    // assertions
    // ****************************************
    logic [IMG_BYTES*8-1:0] unused_bits;
    always_comb begin
        for (int i = 0; i < IMG_BYTES; i++)
            unused_bits[8*i +: 8] = s.in_img[8*i +: 8] & {8{~s.in_used[i]}};
    end

    property p_pd_ack;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg.complete && !ctrl_byte[0][CTL_MODE_BIT])
            |=> (!s.ch[0].stat[7] && !in_image_o[8*chan_base(0, $past(cfg)) + 7]);
    endproperty
    a_pd_ack: assert property (p_pd_ack) else $error("status bit 7 not clear in pd mode");

    property p_reg_ack;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_byte[3][CTL_MODE_BIT]
            |=> (s.ch[3].stat[7:6] == {1'b1, $past(ctrl_byte[3][CTL_RW_BIT])});
    endproperty
    a_reg_ack: assert property (p_reg_ack) else $error("register ack or direction wrong");

    property p_reg_echo;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_byte[1][CTL_MODE_BIT] |=> (s.ch[1].stat[5:0] == $past(ctrl_byte[1][5:0]));
    endproperty
    a_reg_echo: assert property (p_reg_echo) else $error("register number not echoed");

    property p_over;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (adc_valid_i[0] && !ctrl_byte[0][CTL_MODE_BIT]
            && $signed(adc_data_i[0]) > $signed(s.ch[0].ovr))
            |=> (s.ch[0].stat[ST_OVER_BIT] && s.ch[0].stat[ST_ERR_BIT]
                 && s.ch[0].data == $past(s.ch[0].ovr));
    endproperty
    a_over: assert property (p_over) else $error("overrange not flagged");

    property p_under;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (adc_valid_i[2] && !ctrl_byte[2][CTL_MODE_BIT]
            && $signed(adc_data_i[2]) < $signed(s.ch[2].und))
            |=> (s.ch[2].stat[ST_UNDER_BIT] && !s.ch[2].stat[ST_OVER_BIT]);
    endproperty
    a_under: assert property (p_under) else $error("underrange not flagged");

    property p_lim2_off;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (adc_valid_i[0] && !ctrl_byte[0][CTL_MODE_BIT] && !s.ch[0].feat[FEAT_EN_LIM2])
            |=> (s.ch[0].stat[5:4] == LIM_OFF);
    endproperty
    a_lim2_off: assert property (p_lim2_off) else $error("disabled limit 2 not 00");

    property p_lim1_eq;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (adc_valid_i[1] && !ctrl_byte[1][CTL_MODE_BIT] && s.ch[1].feat[FEAT_EN_LIM1]
            && adc_data_i[1] == s.ch[1].lim1
            && $signed(adc_data_i[1]) <= $signed(s.ch[1].ovr)
            && $signed(adc_data_i[1]) >= $signed(s.ch[1].und))
            |=> (s.ch[1].stat[3:2] == LIM_EQUAL);
    endproperty
    a_lim1_eq: assert property (p_lim1_eq) else $error("limit 1 equal not reported");

    property p_unused_zero;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        unused_bits == '0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused byte carries data");

    property p_compact_map;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !cfg.complete |=> (in_used_o == 16'h00ff && out_used_o == 16'h0000);
    endproperty
    a_compact_map: assert property (p_compact_map) else $error("compact map wrong");

    property p_align_map;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg.complete && cfg.align) |=> (in_used_o == 16'hffff
            && in_image_o[15:8] == 8'h00 && in_image_o[47:40] == 8'h00);
    endproperty
    a_align_map: assert property (p_align_map) else $error("aligned map wrong");

    property p_packed_map;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (cfg.complete && !cfg.align && !cfg.motorola)
            |=> (in_used_o == 16'h0fff && in_image_o[15:8] == s.ch[0].data[7:0]);
    endproperty
    a_packed_map: assert property (p_packed_map) else $error("packed map wrong");

    c_reg_write: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_byte[0][7:6] == 2'h3 ##1 s.ch[0].stat[7]);
    c_reg_read: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_byte[0][7:6] == 2'h2 ##1 !ctrl_byte[0][7]);
    c_over: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s.ch[0].stat[ST_OVER_BIT]);
    c_motorola: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        cfg.complete && cfg.motorola && cfg.align);
    c_compact: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !cfg.complete && adc_valid_i[1]);

    // ****************************************
    // handshake and data path checks
    // ****************************************
    // read returns the addressed register's value in the data word
    property p_rd_data;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctrl_byte[2][7:6] == 2'h2 && ctrl_byte[2][5:0] == REG_OVR)
            |=> (s.ch[2].data == $past(s.ch[2].ovr));
    endproperty
    a_rd_data: assert property (p_rd_data) else $error("read data word wrong");

    // write word lands in the addressed register
    property p_wr_take;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ctrl_byte[1][7:6] == 2'h3 && ctrl_byte[1][5:0] == REG_LIM2)
            |=> (s.ch[1].lim2 == $past(wr_word[1]));
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("write word not taken");

    // sample taken whatever the low control bits hold
    property p_pd_take;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!ctrl_byte[3][CTL_MODE_BIT] && adc_valid_i[3])
            |=> (s.ch[3].raw == $past(adc_data_i[3]));
    endproperty
    a_pd_take: assert property (p_pd_take) else $error("pd sample not taken");

    // register traffic leaves the measured value alone
    property p_reg_hold;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_byte[0][CTL_MODE_BIT] |=> (s.ch[0].raw == $past(s.ch[0].raw));
    endproperty
    a_reg_hold: assert property (p_reg_hold) else $error("sample taken in reg mode");

    // flags and value always from the same sample
    property p_pd_pair;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !ctrl_byte[2][CTL_MODE_BIT]
            |=> (s.ch[2].stat == s.ch[2].pd_stat && s.ch[2].data == s.ch[2].pd_data);
    endproperty
    a_pd_pair: assert property (p_pd_pair) else $error("status and data out of step");

endmodule : ccs_chan_regs

//--- verif/ccs_ctl_model.sv
`timescale 1ns/1ps
module ccs_ctl_model
    import ccs_pkg::*;
(
    input  wire logic                    ref_clk_i,
    input  wire ccs_cfg_s                cfg_i,
    input  wire logic [NUM_CH-1:0][7:0]  ctl_i,
    input  wire logic [NUM_CH-1:0][15:0] wr_i,
    output logic      [IMG_BYTES*8-1:0]  out_image_o
);
    // ****************************************
    // output image as the controller builds it
    // ****************************************
    logic [7:0] junk = 8'h5a;
    int         b;

    // filler changes every cycle, so a design that samples it is caught
    always @(posedge ref_clk_i) begin
        junk <= ~junk + 8'h01;
    end

    always_comb begin
        out_image_o = {IMG_BYTES{junk}};
        for (int k = 0; k < NUM_CH; k++) begin
            b = cfg_i.complete ? (cfg_i.align ? 4*k : 3*k) : 2*k;
            if (cfg_i.complete) begin
                out_image_o[8*b +: 8] = ctl_i[k];
                b = b + (cfg_i.align ? DATA_AT_ALIGNED : DATA_AT_PACKED);
            end
            out_image_o[8*b +: 8]     = cfg_i.motorola ? wr_i[k][15:8] : wr_i[k][7:0];
            out_image_o[8*b+8 +: 8]   = cfg_i.motorola ? wr_i[k][7:0] : wr_i[k][15:8];
        end
    end
endmodule : ccs_ctl_model

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ccs_pkg::*;
    typedef struct {int due; int k; ccs_cfg_s cfg; logic [7:0] st; logic [15:0] d;} ccs_note_s;
    logic                      clk = 1'b0;
    logic                      rst_n = 1'b0;
    ccs_cfg_s                  cfg = 3'h5;
    logic [NUM_CH-1:0][15:0]   adc_data = '0;
    logic [NUM_CH-1:0]         adc_valid = '0;
    logic [NUM_CH-1:0][7:0]    ctl = '0;
    logic [NUM_CH-1:0][15:0]   wr = '0;
    logic [IMG_BYTES*8-1:0]    out_image;
    logic [IMG_BYTES*8-1:0]    in_image;
    logic [IMG_BYTES-1:0]      in_used;
    logic [IMG_BYTES-1:0]      out_used;
    logic [15:0]               ovr[NUM_CH], und[NUM_CH], feat[NUM_CH], lim1[NUM_CH], lim2[NUM_CH];
    logic [7:0]                last[NUM_CH];
    logic [15:0]               lastd[NUM_CH];
    logic [15:0]               raw[NUM_CH];
    ccs_note_s                 notes[$];
    ccs_note_s                 nt;
    int                        cyc = 0, error_cnt = 0, comparisons = 0, p, s;
    int                        seed = 32'h0000_f50a;

    always #25 clk = ~clk;

    ccs_chan_regs uut (.ref_clk_i(clk), .rst_n_i(rst_n), .cfg_complete_i(cfg.complete),
        .cfg_motorola_i(cfg.motorola), .cfg_align_i(cfg.align), .adc_data_i(adc_data),
        .adc_valid_i(adc_valid), .out_image_i(out_image), .in_image_o(in_image),
        .in_used_o(in_used), .out_used_o(out_used));
    ccs_ctl_model ctl_model (.ref_clk_i(clk), .cfg_i(cfg), .ctl_i(ctl), .wr_i(wr),
        .out_image_o(out_image));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (error_cnt == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    function automatic int data_at(ccs_cfg_s c, int k);
        return c.complete ? (c.align ? 4*k+2 : 3*k+1) : 2*k;
    endfunction : data_at

    function automatic logic [15:0] exp_used(ccs_cfg_s c, logic o);
        int n;
        n = c.complete ? (c.align ? 16 : 12) : (o ? 0 : 8);
        return 16'((32'h0000_0001 << n) - 1);
    endfunction : exp_used

    function automatic logic [1:0] cmp(logic en, logic [15:0] x, logic [15:0] l);
        if (!en) return LIM_OFF;
        if ($signed(x) < $signed(l)) return LIM_BELOW;
        return ($signed(x) > $signed(l)) ? LIM_ABOVE : LIM_EQUAL;
    endfunction : cmp

    function automatic logic [15:0] rd(int k, logic [5:0] n);
        case (n)
            REG_RAW:  return raw[k];
            REG_DIAG: return {8'h00, last[k]};
            REG_OVR:  return ovr[k];
            REG_UND:  return und[k];
            REG_FEAT: return feat[k];
            REG_LIM1: return lim1[k];
            REG_LIM2: return lim2[k];
            default:  return 16'h0000;
        endcase
    endfunction : rd

    // one request or sample on channel k, answer noted for the next edge
    task automatic step(int k, logic [7:0] c, logic [15:0] w, logic [15:0] v, logic vld);
        ccs_note_s n;
        logic [15:0] x;
        ctl[k] = c;
        wr[k] = w;
        adc_data[k] = v;
        adc_valid[k] = vld;
        n.due = cyc + 1;
        n.k = k;
        n.cfg = cfg;
        if (!cfg.complete || !c[CTL_MODE_BIT]) begin
            if (vld) begin
                x = v;
                raw[k] = v;
                last[k] = 8'h00;
                if ($signed(x) > $signed(ovr[k])) begin
                    x = ovr[k];
                    last[k][ST_OVER_BIT] = 1'b1;
                end else if ($signed(x) < $signed(und[k])) begin
                    x = und[k];
                    last[k][ST_UNDER_BIT] = 1'b1;
                end
                last[k][ST_ERR_BIT] = last[k][ST_OVER_BIT] | last[k][ST_UNDER_BIT];
                last[k][3:2] = cmp(feat[k][FEAT_EN_LIM1], x, lim1[k]);
                last[k][5:4] = cmp(feat[k][FEAT_EN_LIM2], x, lim2[k]);
                lastd[k] = x;
            end
            n.st = last[k];
            n.d = lastd[k];
        end else begin
            if (c[CTL_RW_BIT]) begin
                case (c[5:0])
                    REG_OVR:  ovr[k] = w;
                    REG_UND:  und[k] = w;
                    REG_FEAT: feat[k] = w;
                    REG_LIM1: lim1[k] = w;
                    REG_LIM2: lim2[k] = w;
                    default:  ;
                endcase
            end
            n.st = c;
            n.d = rd(k, c[5:0]);
        end
        notes.push_back(n);
        // request held until the echo edge has passed
        @(posedge clk);
        #2;
        adc_valid = '0;
    endtask : step

    // ****************************************
    // monitor, timeout and main sequence
    // ****************************************
    always @(negedge clk) begin
        while (notes.size() > 0 && notes[0].due == cyc) begin
            nt = notes.pop_front();
            p = data_at(nt.cfg, nt.k);
            s = p - (nt.cfg.align ? DATA_AT_ALIGNED : DATA_AT_PACKED);
            check(nt.cfg.motorola ? {in_image[8*p +: 8], in_image[8*p+8 +: 8]} :
                  {in_image[8*p+8 +: 8], in_image[8*p +: 8]}, nt.d);
            if (nt.cfg.complete) check({8'h00, in_image[8*s +: 8]}, {8'h00, nt.st});
            if (nt.cfg.complete && nt.cfg.align) check({8'h00, in_image[8*s+8 +: 8]}, 16'h0000);
            check(in_used, exp_used(nt.cfg, 1'b0));
            check(out_used, exp_used(nt.cfg, 1'b1));
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc > 1000) begin
            error_cnt++;
            $display("BAD %0t run did not finish", $time);
            results();
        end
    end

    initial begin
        for (int k = 0; k < NUM_CH; k++) begin
            ovr[k] = OVR_RST;
            und[k] = UND_RST;
            feat[k] = FEAT_RST;
            lim1[k] = LIM_RST;
            lim2[k] = LIM_RST;
            last[k] = 8'h00;
            lastd[k] = 16'h0000;
            raw[k] = 16'h0000;
        end
        repeat (5) @(posedge clk);
        #2;
        rst_n = 1'b1;
        for (int k = 0; k < NUM_CH; k++) begin
            step(k, {2'b10, REG_OVR}, 16'h0000, 16'h0000, 1'b0);
            step(k, {2'b10, REG_UND}, 16'h0000, 16'h0000, 1'b0);
            step(k, {2'b10, REG_FEAT}, 16'h0000, 16'h0000, 1'b0);
            step(k, {2'b11, REG_DIAG}, 16'($random(seed)), 16'h0000, 1'b0);
            step(k, {2'b11, REG_LIM1}, 16'(100 + k), 16'h0000, 1'b0);
            step(k, {2'b11, REG_LIM2}, 16'(200 + k), 16'h0000, 1'b0);
            if (k < 3) step(k, {2'b11, REG_FEAT}, FEAT_RST | 16'h0600, 16'h0000, 1'b0);
            step(k, {2'b10, REG_LIM1}, 16'h0000, 16'h0000, 1'b0);
            step(k, 8'h7f, 16'h0000, 16'(100 + k), 1'b1);
            step(k, 8'h00, 16'h0000, 16'(99 + k), 1'b1);
            step(k, 8'h00, 16'h0000, 16'(200 + k), 1'b1);
            step(k, 8'h00, 16'h0000, 16'(201 + k), 1'b1);
            step(k, 8'h00, 16'h0000, 16'h1000, 1'b1);
            step(k, 8'h00, 16'h0000, 16'hfffb, 1'b1);
            step(k, {2'b10, REG_DIAG}, 16'h0000, 16'h0000, 1'b0);
            step(k, 8'h00, 16'h0000, 16'h0fff, 1'b1);
            step(k, {2'b10, REG_RAW}, 16'h0000, 16'h0000, 1'b0);
        end
        for (int i = 0; i < 8; i++) begin
            cfg = ccs_cfg_s'(3'(i));
            for (int j = 0; j < 6; j++) begin
                step($unsigned($random(seed)) % NUM_CH, 8'h00, 16'($random(seed)),
                     16'($random(seed) & 32'h0000_1fff), 1'b1);
            end
        end
        repeat (3) @(posedge clk);
        results();
    end
endmodule : tb_top
